//--- hdl/vgt_pkg.sv
package vgt_pkg;
    localparam int unsigned VGT_WORD_BITS = 16;
    localparam int unsigned VGT_BYTE_BITS = 8;
    localparam int unsigned VGT_CNT_BITS = 4;
    localparam int unsigned VGT_ADDR_BITS = 7;
    localparam int unsigned VGT_NUM_REGS = 8;
    localparam logic [6:0] VGT_ADDR_GAIN = 7'h02;
    localparam logic [6:0] VGT_ADDR_TBGAIN = 7'h04;
    localparam logic [6:0] VGT_ADDR_TBFREQ = 7'h05;
    localparam logic [7:0] VGT_RST_GAIN = 8'h20;
    localparam logic [7:0] VGT_RST_TBGAIN = 8'h27;
    localparam logic [7:0] VGT_RST_TBFREQ = 8'h45;
    localparam int unsigned VGT_OFF_BIT = 5;
    localparam int unsigned VGT_CODE_MSB = 4;
    localparam int unsigned VGT_GAIN_MSB = 5;
    localparam logic [5:0] VGT_ATTEN_MAX = 6'h20;
    localparam int unsigned VGT_RW_BIT = 15;
endpackage

//--- hdl/vgt_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module vgt_regfile
    import vgt_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [VGT_ADDR_BITS-1:0] addr_in,
    input wire logic [VGT_BYTE_BITS-1:0] wr_data_in,
    output logic [VGT_BYTE_BITS-1:0] rd_data_out,
    output logic [VGT_BYTE_BITS-1:0] gain_out,
    output logic [VGT_BYTE_BITS-1:0] tbgain_out,
    output logic [VGT_BYTE_BITS-1:0] tbfreq_out
);
    logic [VGT_BYTE_BITS-1:0] gain_r;
    logic [VGT_BYTE_BITS-1:0] tbgain_r;
    logic [VGT_BYTE_BITS-1:0] tbfreq_r;

    // Power-on defaults
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            gain_r <= VGT_RST_GAIN;
            tbgain_r <= VGT_RST_TBGAIN;
            tbfreq_r <= VGT_RST_TBFREQ;
        end else if (wr_en_in) begin
            unique case (addr_in)
                VGT_ADDR_GAIN: gain_r <= wr_data_in;
                VGT_ADDR_TBGAIN: tbgain_r <= wr_data_in;
                VGT_ADDR_TBFREQ: tbfreq_r <= wr_data_in;
                default: ;
            endcase
        end
    end

    // Registered readback; unmapped addresses read zero
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 8'h00;
        end else begin
            unique case (addr_in)
                VGT_ADDR_GAIN: rd_data_out <= gain_r;
                VGT_ADDR_TBGAIN: rd_data_out <= tbgain_r;
                VGT_ADDR_TBFREQ: rd_data_out <= tbfreq_r;
                default: rd_data_out <= 8'h00;
            endcase
        end
    end

    assign gain_out = gain_r;
    assign tbgain_out = tbgain_r;
    assign tbfreq_out = tbfreq_r;
endmodule // vgt_regfile
`default_nettype wire

//--- hdl/vgt_regs.sv
// Functional notes
// - Thermal gain register bit 5 high turns thermal correction off; resets high.
// - Correction-gain code in bits 4..0, resets to 00111.
// - Boost-frequency register at address 5h, read/write, resets to 45h.
// - Boost-frequency code in bits 4..0, resets to 00101.
// - Codes 00h..1Fh give attenuation equal to code, 1 dB steps.
// - Codes 20h..3Fh saturate at 32 dB attenuation.
// - Thermal correction starts disabled; enabled by writing zero to off bit.
// - Gain code sets boost amount, frequency code sets boost placement.
// - 16-bit words, rising edges, select low, address then data.
// - Reset loads all defaults: gain 20h, thermal gain 27h, boost frequency 45h.
`timescale 1ns/1ps
`default_nettype none
module vgt_regs
    import vgt_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic [5:0] atten_db_out,
    output logic power_down_out,
    output logic thermal_correction_off_out,
    output logic [4:0] boost_gain_code_out,
    output logic [4:0] boost_freq_code_out
);
    // Serial pins are sampled in the system clock; sclk must stay below clock/4
    logic [2:0] sclk_sync_r;
    logic [1:0] cs_sync_r;
    logic [1:0] sdi_sync_r;
    logic [VGT_CNT_BITS-1:0] bit_cnt_r;
    logic [VGT_WORD_BITS-2:0] shift_r;
    logic [VGT_BYTE_BITS-1:0] sdo_shift_r;
    logic wr_en_r;
    logic [VGT_ADDR_BITS-1:0] addr_r;
    logic [VGT_BYTE_BITS-1:0] wdata_r;
    logic load_sdo_r;
    logic load_sdo_d_r;
    logic [VGT_BYTE_BITS-1:0] rd_data;
    logic [VGT_BYTE_BITS-1:0] gain_q;
    logic [VGT_BYTE_BITS-1:0] tbgain_q;
    logic [VGT_BYTE_BITS-1:0] tbfreq_q;
    logic sclk_rise;
    logic sclk_fall;
    logic selected;
    logic addr_done;
    logic word_done;
    logic [VGT_WORD_BITS-1:0] word_nxt;

    // Saturating attenuation decode
    function automatic logic [5:0] atten_of(input logic [VGT_BYTE_BITS-1:0] code);
        if (code[VGT_GAIN_MSB]) begin
            return VGT_ATTEN_MAX;
        end
        return code[VGT_GAIN_MSB:0];
    endfunction

    // Counter must span exactly one word
    if ((1 << VGT_CNT_BITS) != VGT_WORD_BITS) begin : g_bad_count
        $error("Bit counter does not match word length");
    end

    // Address and read flag must fill one byte
    if (VGT_ADDR_BITS + 1 != VGT_BYTE_BITS) begin : g_bad_addr
        $error("Address and flag must fill one byte");
    end

    // Serial clock keeps a third stage for edge detection
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_sync_r <= 3'h0;
        end else begin
            sclk_sync_r <= {sclk_sync_r[1:0], sclk_in};
        end
    end

    // Select resets high, so no false frame follows reset
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cs_sync_r <= 2'h3;
        end else begin
            cs_sync_r <= {cs_sync_r[0], cs_n_in};
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sdi_sync_r <= 2'h0;
        end else begin
            sdi_sync_r <= {sdi_sync_r[0], sdi_in};
        end
    end

    assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
    assign sclk_fall = ~sclk_sync_r[1] & sclk_sync_r[2];
    assign selected = ~cs_sync_r[1];
    assign addr_done = selected & sclk_rise & (bit_cnt_r == 4'h7);
    assign word_done = selected & sclk_rise & (bit_cnt_r == 4'hF);
    assign word_nxt = {shift_r, sdi_sync_r[1]};

    // Deselect restarts the count, so a partial word is dropped
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            bit_cnt_r <= '0;
        end else if (!selected) begin
            bit_cnt_r <= '0;
        end else if (sclk_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // Bits enter MSB first on rising edges
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            shift_r <= '0;
        end else if (selected && sclk_rise) begin
            shift_r <= word_nxt[VGT_WORD_BITS-2:0];
        end
    end

    // Address known after eight bits: fetch readback for the data phase
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            addr_r <= '0;
        end else if (addr_done) begin
            addr_r <= word_nxt[VGT_ADDR_BITS-1:0];
        end
    end

    // Register file answers one cycle after the address settles
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            load_sdo_r <= 1'b0;
            load_sdo_d_r <= 1'b0;
        end else begin
            load_sdo_r <= addr_done & word_nxt[VGT_BYTE_BITS-1];
            load_sdo_d_r <= load_sdo_r;
        end
    end

    // MSB of address byte selects read (1) or write (0)
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wr_en_r <= 1'b0;
            wdata_r <= '0;
        end else begin
            wr_en_r <= word_done & ~word_nxt[VGT_RW_BIT];
            if (word_done) begin
                wdata_r <= word_nxt[VGT_BYTE_BITS-1:0];
            end
        end
    end

    vgt_regfile u_regfile (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .wr_en_in(wr_en_r),
        .addr_in(addr_r),
        .wr_data_in(wdata_r),
        .rd_data_out(rd_data),
        .gain_out(gain_q),
        .tbgain_out(tbgain_q),
        .tbfreq_out(tbfreq_q)
    );

    // Readback shifts out MSB first on falling edges
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sdo_shift_r <= '0;
            sdo_out <= 1'b0;
        end else begin
            if (load_sdo_d_r) begin
                sdo_shift_r <= rd_data;
            end else if (selected && sclk_fall && bit_cnt_r >= 4'h8) begin
                sdo_out <= sdo_shift_r[VGT_BYTE_BITS-1];
                sdo_shift_r <= {sdo_shift_r[VGT_BYTE_BITS-2:0], 1'b0};
            end
        end
    end

    // Analog control decode, registered so outputs never glitch
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            atten_db_out <= VGT_ATTEN_MAX;
        end else begin
            atten_db_out <= atten_of(gain_q);
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            power_down_out <= 1'b0;
        end else begin
            power_down_out <= gain_q[VGT_GAIN_MSB+1];
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            thermal_correction_off_out <= 1'b1;
        end else begin
            thermal_correction_off_out <= tbgain_q[VGT_OFF_BIT];
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            boost_gain_code_out <= VGT_RST_TBGAIN[VGT_CODE_MSB:0];
        end else begin
            boost_gain_code_out <= tbgain_q[VGT_CODE_MSB:0];
        end
    end

    // Frequency code moves independently of the gain code
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            boost_freq_code_out <= VGT_RST_TBFREQ[VGT_CODE_MSB:0];
        end else begin
            boost_freq_code_out <= tbfreq_q[VGT_CODE_MSB:0];
        end
    end
endmodule // vgt_regs
`default_nettype wire

//--- sim/vgt_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module vgt_regs_properties (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic cs_n_in,
    input wire logic [5:0] atten_db_out,
    input wire logic thermal_correction_off_out,
    input wire logic [4:0] boost_gain_code_out,
    input wire logic [4:0] boost_freq_code_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    a_atten_sat: assert property (atten_db_out <= 6'd32) else $error("atten over 32");
    a_off_reset: assert property ($fell(rst_in) |-> thermal_correction_off_out)
        else $error("off low at reset");
    a_gain_reset: assert property ($fell(rst_in) |-> boost_gain_code_out == 5'h07)
        else $error("gain code reset");
    a_freq_reset: assert property ($fell(rst_in) |-> boost_freq_code_out == 5'h05)
        else $error("freq code reset");
    a_atten_reset: assert property ($fell(rst_in) |-> atten_db_out == 6'd32)
        else $error("atten reset");
    a_idle_hold: assert property (cs_n_in [*8] |=> $stable(atten_db_out))
        else $error("change while idle");
    a_fields_apart: assert property ($changed(boost_gain_code_out) |->
        $stable(boost_freq_code_out)) else $error("codes moved together");
    a_write_framed: assert property ($changed(boost_freq_code_out) |-> !$past(cs_n_in, 3))
        else $error("write outside select");
    c_corr_on: cover property ($fell(thermal_correction_off_out));
    c_full_gain: cover property (atten_db_out == 6'd0);
    c_freq_max: cover property (boost_freq_code_out == 5'h1F);
endmodule // vgt_regs_properties
bind vgt_regs vgt_regs_properties i_props (.clock_in, .rst_in, .cs_n_in, .atten_db_out,
    .thermal_correction_off_out, .boost_gain_code_out, .boost_freq_code_out);
`default_nettype wire

//--- sim/vgt_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module vgt_spi_host (
    input wire logic clock_in,
    input wire logic sdo_in,
    output logic sclk_out = 1'b0,
    output logic cs_n_out = 1'b1,
    output logic sdi_out = 1'b0
);
    // Phases of 4 clocks or more, so the synchroniser never misses an edge
    task automatic frame(input logic [31:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        for (int i = 0; i < n; i++) begin
            @(negedge clock_in);
            cs_n_out <= 1'b0;
            sdi_out <= w[31-i];
            repeat (4) @(negedge clock_in);
            sclk_out <= 1'b1;
            rd = {rd[6:0], sdo_in};
            repeat (4) @(negedge clock_in);
            sclk_out <= 1'b0;
        end
        repeat (4) @(negedge clock_in);
        cs_n_out <= 1'b1;
        sdi_out <= ~sdi_out;
    endtask
endmodule // vgt_spi_host
`default_nettype wire

//--- sim/tb_vgt_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module tb_vgt_regs;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic sclk, cs_n, sdi, sdo, off, pd;
    logic [5:0] atten;
    logic [4:0] bg, bf;
    logic [7:0] rd;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    always #4 clock_in = ~clock_in;
    vgt_spi_host i_host (.clock_in, .sdo_in(sdo), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi));
    vgt_regs i_dut (.clock_in, .rst_in, .sclk_in(sclk), .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo),
        .atten_db_out(atten), .power_down_out(pd), .thermal_correction_off_out(off),
        .boost_gain_code_out(bg), .boost_freq_code_out(bf));
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_host.frame({1'b0, a, d, 16'h0000}, 16, rd);
    endtask
    task automatic rdr(input logic [6:0] a, input logic [7:0] e);
        i_host.frame({1'b1, a, 24'h00_0000}, 16, rd);
        `CHK(rd, e)
    endtask
    task automatic t_defaults;
        `CHK(atten, 6'd32)
        `CHK(off, 1'b1)
        `CHK(bg, 5'h07)
        `CHK(bf, 5'h05)
        `CHK(pd, 1'b0)
        rdr(7'h02, 8'h20);
        rdr(7'h04, 8'h27);
        rdr(7'h05, 8'h45);
    endtask
    task automatic t_gain;
        logic [5:0] c[5] = '{6'h00, 6'h01, 6'h1F, 6'h20, 6'h3F};
        wr(7'h02, 8'h47);
        `CHK(atten, 6'd7)
        `CHK(pd, 1'b1)
        for (int i = 0; i < 5; i++) begin
            wr(7'h02, {2'b00, c[i]});
            `CHK(atten, (c[i] > 6'h1F) ? 6'd32 : c[i])
        end
        `CHK(pd, 1'b0)
    endtask
    task automatic t_thermal;
        wr(7'h04, 8'h1F);
        `CHK(off, 1'b0)
        `CHK(bg, 5'h1F)
        `CHK(bf, 5'h05)
        wr(7'h05, 8'h40);
        `CHK(bf, 5'h00)
        `CHK(bg, 5'h1F)
        wr(7'h04, 8'h20);
        `CHK(off, 1'b1)
        rdr(7'h05, 8'h40);
    endtask
    task automatic t_stream;
        i_host.frame({8'h02, 8'h11, 8'h05, 8'h5F}, 32, rd);
        `CHK(atten, 6'd17)
        `CHK(bf, 5'h1F)
        // Trailing partial word must be dropped at deselect
        i_host.frame(32'h0203_0200, 20, rd);
        `CHK(atten, 6'd3)
        wr(7'h02, 8'h07);
        `CHK(atten, 6'd7)
        wr(7'h10, 8'h3F);
        rdr(7'h10, 8'h00);
        `CHK(atten, 6'd7)
    endtask
    task automatic end_sim;
        if (fails == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(negedge clock_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clock_in);
        t_defaults();
        t_gain();
        t_thermal();
        t_stream();
        rst_in = 1'b1;
        @(negedge clock_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clock_in);
        t_defaults();
        end_sim();
    end
endmodule // tb_vgt_regs
`default_nettype wire
